// *** verilog/cch_cache_ctrl.sv ***
// Segmented buffer cache controller between host commands and the medium
`default_nettype none

module cch_cache_ctrl
    import cch_pkg::*;
#(
    parameter int BUF_KB = 512,
    parameter int LEN_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Mode settings
    input wire logic read_cache_disable,
    input wire logic write_cache_enable_flag,
    input wire logic read_ahead_disable,
    input wire logic param_check_a,
    // Segmentation set-up
    input wire logic cfg_wr,
    input wire logic [4:0] cfg_seg_count,
    input wire logic cfg_size_sent,
    output logic cfg_reject,
    output logic [4:0] seg_count,
    output logic [15:0] seg_size_rpt,
    output logic prefetch_en,
    // Host commands and status
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic [LBA_W-1:0] cmd_lba,
    input wire logic [LEN_W-1:0] cmd_len,
    output logic cmd_done,
    output logic cmd_good,
    output logic deferred_err,
    input wire logic deferred_clr,
    output logic xfer_paced,
    output logic spindle_stop,
    // Host write blocks
    input wire logic wr_valid,
    output logic wr_ready,
    // Host read blocks
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [LBA_W-1:0] rd_lba,
    // Medium read/write path
    output logic med_req,
    output logic med_wr,
    output logic [LBA_W-1:0] med_lba,
    input wire logic med_ack,
    input wire logic med_err
);

    // Blocks usable for caching once the reserved region is set aside
    localparam int AVAIL_BLK = (BUF_KB - RES_KB) * KB_BYTES / SECTOR_BYTES;

    typedef struct packed {
        cch_state_type st;
        logic [4:0] seg_num;
        logic [LBA_W-1:0] lba;
        logic [LEN_W-1:0] left;
        logic [3:0] cur;
        logic [3:0] wseg;
        logic [CNT_W-1:0] wdirty;
        logic [LBA_W-1:0] clba;
        logic early;
        logic werr;
        logic op_stop;
        logic med_req;
        logic med_wr;
        logic [LBA_W-1:0] med_lba;
        logic done;
        logic good;
        logic dferr;
        logic paced;
        logic stop;
        logic rej;
        logic rdy;
        logic wrdy;
        logic pf;
        logic [15:0] rpt;
        cch_seg_type [SEG_MAX-1:0] tbl;
    } cch_ctl_type;

    cch_ctl_type q;
    cch_ctl_type d;

    logic [CNT_W-1:0] cap;
    logic [SEG_MAX-1:0] seg_on;
    logic [SEG_MAX-1:0] seg_hit;
    logic [SEG_MAX-1:0] seg_ovl;
    logic [SEG_MAX-1:0] seg_keep;
    logic [3:0] vic;
    logic [3:0] hidx;
    logic found;
    logic [AGE_W-1:0] best;
    logic inc;
    logic dec;
    logic set_def;
    logic tch_en;
    logic [3:0] tch_idx;
    logic push_v;
    logic push_rdy;
    logic [LBA_W-1:0] push_lba;

    // Ring length follows only from the segment count
    assign cap = CNT_W'(AVAIL_BLK / int'(q.seg_num));

    // Append one block to a segment ring; a full ring drops its oldest block
    function automatic cch_seg_type seg_push(cch_seg_type e, logic [CNT_W-1:0] lim);
        cch_seg_type r;
        r = e;
        if (e.cnt >= lim) begin
            r.base = e.base + 1'h1;
        end else begin
            r.cnt = e.cnt + 1'h1;
        end
        return r;
    endfunction : seg_push

    // Per-segment address compare for hits and write overlap
    for (genvar g = 0; g < SEG_MAX; g++) begin : g_seg
        logic [LBA_W-1:0] roff;
        logic [LBA_W-1:0] woff;
        logic [LBA_W-1:0] boff;
        assign roff = q.lba - q.tbl[g].base;
        assign woff = cmd_lba - q.tbl[g].base;
        assign boff = q.tbl[g].base - cmd_lba;
        assign seg_on[g] = 5'(g) < q.seg_num;
        assign seg_keep[g] = (4'(g) == q.wseg) && (q.wdirty != '0);
        assign seg_hit[g] = seg_on[g] && q.tbl[g].valid && (roff < LBA_W'(q.tbl[g].cnt));
        assign seg_ovl[g] = seg_on[g] && q.tbl[g].valid
            && ((woff < LBA_W'(q.tbl[g].cnt)) || (boff < LBA_W'(cmd_len)));
    end

    // Victim choice: a free segment first, else the oldest clean one
    always_comb begin
        found = 1'h0;
        vic = '0;
        best = '0;
        hidx = '0;
        for (int i = 0; i < SEG_MAX; i++) begin
            if (seg_on[i] && !seg_keep[i] && !q.tbl[i].valid && !found) begin
                vic = 4'(i);
                found = 1'h1;
            end
        end
        for (int i = 0; i < SEG_MAX; i++) begin
            if (!found && seg_on[i] && !seg_keep[i] && q.tbl[i].age >= best) begin
                vic = 4'(i);
                best = q.tbl[i].age;
            end
        end
        // Any segment may serve the next block, so hits span segments
        for (int i = SEG_MAX - 1; i >= 0; i--) begin
            if (seg_hit[i]) begin
                hidx = 4'(i);
            end
        end
    end

    // Next-state logic of the whole controller
    always_comb begin
        d = q;
        inc = 1'h0;
        dec = 1'h0;
        set_def = 1'h0;
        tch_en = 1'h0;
        tch_idx = '0;
        push_v = 1'h0;
        push_lba = q.lba;
        d.done = 1'h0;
        d.rej = 1'h0;
        d.rpt = SIZE_RPT;
        d.pf = !read_ahead_disable;

        // Commit engine drains the dirty ring whenever the medium is free
        if (q.med_req && med_ack) begin
            d.med_req = 1'h0;
            if (q.med_wr) begin
                dec = 1'h1;
                d.clba = q.clba + 1'h1;
                if (med_err && q.early) begin
                    set_def = 1'h1;
                end else if (med_err) begin
                    d.werr = 1'h1;
                end
            end
        end else if (!q.med_req && q.wdirty != '0) begin
            d.med_req = 1'h1;
            d.med_wr = 1'h1;
            d.med_lba = q.clba;
        end

        case (q.st)
            ST_IDLE: begin
                if (cmd_valid && q.rdy) begin
                    d.lba = cmd_lba;
                    d.left = cmd_len;
                    d.werr = 1'h0;
                    d.early = 1'h0;
                    d.good = 1'h1;
                    case (cch_op_type'(cmd_op))
                        OP_READ: begin
                            d.st = ST_RLOOK;
                        end
                        OP_WRITE: begin
                            // With read cache enabled, stale copies of the written blocks must not hit later
                            for (int i = 0; i < SEG_MAX; i++) begin
                                if (seg_ovl[i] && !read_cache_disable) begin
                                    d.tbl[i].valid = 1'h0;
                                end
                            end
                            d.tbl[vic] = '{valid: !read_cache_disable, base: cmd_lba,
                                           cnt: '0, age: '0};
                            d.wseg = vic;
                            d.clba = cmd_lba;
                            tch_en = 1'h1;
                            tch_idx = vic;
                            d.st = ST_WRITE;
                        end
                        OP_SYNC: begin
                            d.st = ST_SYNC;
                        end
                        OP_STOP: begin
                            d.op_stop = 1'h1;
                            d.st = ST_SYNC;
                        end
                        OP_START: begin
                            d.stop = 1'h0;
                            d.done = 1'h1;
                        end
                        default: begin
                            d.done = 1'h1;
                            d.good = 1'h0;
                        end
                    endcase
                end
            end
            ST_RLOOK: begin
                if (q.left == '0) begin
                    d.done = 1'h1;
                    d.st = ST_IDLE;
                end else if (!read_cache_disable && (|seg_hit)) begin
                    // Hit data is already here: no buffer-full pacing
                    d.paced = 1'h0;
                    if (push_rdy) begin
                        push_v = 1'h1;
                        d.lba = q.lba + 1'h1;
                        d.left = q.left - 1'h1;
                        tch_en = 1'h1;
                        tch_idx = hidx;
                    end
                end else begin
                    // Miss, or lookup bypassed: rest comes from the medium
                    d.tbl[vic] = '{valid: !read_cache_disable, base: q.lba,
                                   cnt: '0, age: '0};
                    d.cur = vic;
                    d.paced = 1'h1;
                    tch_en = 1'h1;
                    tch_idx = vic;
                    d.st = ST_RFETCH;
                end
            end
            ST_RFETCH: begin
                if (q.left == '0) begin
                    d.done = 1'h1;
                    d.good = !q.werr;
                    d.paced = 1'h0;
                    d.st = ST_IDLE;
                end else if (q.med_req && med_ack && !q.med_wr) begin
                    if (med_err) begin
                        d.werr = 1'h1;
                    end else begin
                        push_v = 1'h1;
                        d.tbl[q.cur] = seg_push(q.tbl[q.cur], cap);
                    end
                    d.lba = q.lba + 1'h1;
                    d.left = q.left - 1'h1;
                end else if (!q.med_req && push_rdy) begin
                    // Request only with room, so the answer can always be pushed
                    d.med_req = 1'h1;
                    d.med_wr = 1'h0;
                    d.med_lba = q.lba;
                end
            end
            ST_WRITE: begin
                if (wr_valid && q.wrdy) begin
                    inc = 1'h1;
                    d.left = q.left - 1'h1;
                    d.tbl[q.wseg] = seg_push(q.tbl[q.wseg], cap);
                end
                if (q.left == '0 && write_cache_enable_flag && !q.werr) begin
                    d.done = 1'h1;
                    d.early = 1'h1;
                    d.st = ST_IDLE;
                end else if (q.left == '0 && q.wdirty == '0 && !q.med_req) begin
                    d.done = 1'h1;
                    d.good = !q.werr;
                    d.st = ST_IDLE;
                end
            end
            ST_SYNC: begin
                if (q.wdirty == '0 && !q.med_req) begin
                    d.done = 1'h1;
                    d.good = !q.werr;
                    d.stop = q.stop | q.op_stop;
                    d.op_stop = 1'h0;
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        d.wdirty = q.wdirty + CNT_W'(inc) - CNT_W'(dec);
        // A new failure wins over a clear in the same cycle
        d.dferr = set_def | (q.dferr & !deferred_clr);

        // Repartition only while idle and clean; read cache setting untouched
        if (cfg_wr) begin
            if (!q.rdy || cmd_valid || cfg_seg_count < SEG_MIN || cfg_seg_count > SEG_TOP
                || (cfg_size_sent && param_check_a)) begin
                d.rej = 1'h1;
            end else begin
                d.seg_num = cfg_seg_count;
                for (int i = 0; i < SEG_MAX; i++) begin
                    d.tbl[i].valid = 1'h0;
                end
            end
        end

        // Age every segment; the one just used becomes the youngest
        if (tch_en) begin
            for (int i = 0; i < SEG_MAX; i++) begin
                if (4'(i) == tch_idx) begin
                    d.tbl[i].age = '0;
                end else if (d.tbl[i].age != '1) begin
                    d.tbl[i].age = d.tbl[i].age + 1'h1;
                end
            end
        end

        // Handshake readies registered from the next state
        d.rdy = (d.st == ST_IDLE) && (d.wdirty == '0) && !d.med_req;
        d.wrdy = (d.st == ST_WRITE) && (d.left != '0) && (d.wdirty < cap);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.seg_num <= SEG_DEF;
            q.rpt <= SIZE_RPT;
        end else begin
            q <= d;
        end
    end

    // Read blocks leave through the skid buffer so a host stall loses none
    cch_skid #(
        .W(LBA_W)
    ) u_rd_buf (
        .clk(clk),
        .resetn(resetn),
        .in_valid(push_v),
        .in_ready(push_rdy),
        .in_data(push_lba),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_lba)
    );

    // Outputs straight from the state flops
    assign cfg_reject = q.rej;
    assign seg_count = q.seg_num;
    assign seg_size_rpt = q.rpt;
    assign prefetch_en = q.pf;
    assign cmd_ready = q.rdy;
    assign cmd_done = q.done;
    assign cmd_good = q.good;
    assign deferred_err = q.dferr;
    assign xfer_paced = q.paced;
    assign spindle_stop = q.stop;
    assign wr_ready = q.wrdy;
    assign med_req = q.med_req;
    assign med_wr = q.med_wr;
    assign med_lba = q.med_lba;

    // Checks on the controller's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_early_fail;
        q.early && q.med_req && q.med_wr && med_ack && med_err;
    endsequence

    sequence s_sync_end;
        (q.st == ST_SYNC) ##1 cmd_done;
    endsequence

    sequence s_fetch_ok;
        (q.st == ST_RFETCH) && (q.left != '0) && q.med_req && !q.med_wr && med_ack && !med_err;
    endsequence

    a_size_report: assert property (seg_size_rpt == SIZE_RPT)
        else $error("Segment size report is not all ones");

    a_seg_range: assert property (seg_count >= SEG_MIN && seg_count <= SEG_TOP)
        else $error("Segment count out of range");

    a_param_check_a_reject: assert property ((cfg_wr && cfg_size_sent && param_check_a) |=> cfg_reject)
        else $error("Param_check_a size change was not rejected");

    a_bypass_fetch: assert property ((q.st == ST_RLOOK && read_cache_disable && q.left != '0) |=> (q.st == ST_RFETCH && xfer_paced))
        else $error("Disabled read cache did not go to the medium");

    a_hit_unpaced: assert property ((q.st == ST_RLOOK && !read_cache_disable && (|seg_hit) && q.left != '0) |=> !xfer_paced)
        else $error("Hit transfer was paced");

    a_fetch_push: assert property (s_fetch_ok |=> rd_valid)
        else $error("Fetched block did not reach the host path");

    a_write_stall: assert property (wr_ready |-> (q.wdirty < cap))
        else $error("Write accepted into a ring full of uncommitted data");

    a_wce_early: assert property ((q.st == ST_WRITE && q.left == '0 && write_cache_enable_flag && !q.werr) |=> (cmd_done && cmd_good))
        else $error("Early write completion missing");

    a_deferred_raise: assert property (s_early_fail |=> deferred_err)
        else $error("Deferred error not raised");

    a_sync_drained: assert property (s_sync_end |-> ($past(q.wdirty) == '0))
        else $error("Flush completed with dirty blocks");

    a_stop_flushed: assert property ($rose(spindle_stop) |-> (cmd_done && q.wdirty == '0))
        else $error("Spindle stopped before write data was flushed");

endmodule : cch_cache_ctrl

`default_nettype wire

// *** shared/cch_pkg.sv ***
// Package: constants and types of the segmented buffer cache controller
// Notes on behaviour
// - Whole buffer caches except reserved 100 Kbyte region
// - Host sets segment count; buffer partitioned accordingly
// - Any segment count from one to sixteen
// - Each segment keeps its block address table
// - Read cache enabled: search buffer before medium
// - Read cache disabled: medium only, pass-through segments
// - Miss transfers paced; hit transfers unpaced
// - Cached first block: send contiguous cached blocks
// - First absent block: fetch it and rest
// - Uncached first block: fetch all into segment
// - Each segment is a sector-granular ring
// - Segment size follows count; size reads all ones
// - Host segment size ignored; param_check_a flag rejects
// - Read cache enabled: written blocks stay cached
// - Read cache enabled: write invalidates segments holding written blocks
// - Write wraps but never overwrites uncommitted data
// - Write cache enabled: good once data buffered
// - Failed commit after early good: deferred error
// - Flush completes only after all writes committed
// - Stop command flushes write data before stopping
// - Segmentation independent of read cache disable
// - Prefetch and caching enabled independently
// - Read-ahead disable zero enables prefetch
`default_nettype none

package cch_pkg;

    // Widths of block addresses, ring counts and ages
    localparam int LBA_W = 16;
    localparam int CNT_W = 12;
    localparam int AGE_W = 4;

    // Segmentation limits and defaults
    localparam int SEG_MAX = 16;
    localparam logic [4:0] SEG_MIN = 5'h01;
    localparam logic [4:0] SEG_TOP = 5'h10;
    localparam logic [4:0] SEG_DEF = 5'h01;
    localparam logic [15:0] SIZE_RPT = 16'hffff;

    // Buffer geometry
    localparam int RES_KB = 100;
    localparam int KB_BYTES = 1024;
    localparam int SECTOR_BYTES = 512;

    // Host command codes
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_SYNC = 3'h2,
        OP_STOP = 3'h3,
        OP_START = 3'h4
    } cch_op_type;

    // Controller states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RLOOK = 3'h1,
        ST_RFETCH = 3'h2,
        ST_WRITE = 3'h3,
        ST_SYNC = 3'h4
    } cch_state_type;

    // One segment's address table entry: a contiguous run base..base+cnt-1
    typedef struct packed {
        logic valid;
        logic [LBA_W-1:0] base;
        logic [CNT_W-1:0] cnt;
        logic [AGE_W-1:0] age;
    } cch_seg_type;

endpackage : cch_pkg

`default_nettype wire

// *** verilog/cch_skid.sv ***
// Two-entry skid buffer on the host read block path
`default_nettype none

module cch_skid #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    typedef struct packed {
        logic ov;
        logic sv;
        logic [W-1:0] od;
        logic [W-1:0] sd;
    } cch_skid_type;

    cch_skid_type q;
    cch_skid_type d;

    // Output stage refills from the skid first, so order is kept
    always_comb begin
        d = q;
        if (out_ready || !q.ov) begin
            if (q.sv) begin
                d.ov = 1'h1;
                d.od = q.sd;
                d.sv = 1'h0;
            end else begin
                d.ov = in_valid;
                if (in_valid) begin
                    d.od = in_data;
                end
            end
        end else if (in_valid && !q.sv) begin
            d.sv = 1'h1;
            d.sd = in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Ready only from flops: a stall never loses a word in flight
    assign in_ready = !q.sv;
    assign out_valid = q.ov;
    assign out_data = q.od;

endmodule : cch_skid

`default_nettype wire

// *** verif/cch_medium_model.sv ***
// Medium model: answers each controller request after a set delay
`default_nettype none

module cch_medium_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Controller request
    input wire logic med_req,
    input wire logic med_wr,
    // Delay and commit failure set by the bench
    input wire logic [3:0] lat,
    input wire logic fail_wr,
    // Answer
    output logic med_ack,
    output logic med_err
);
    logic [3:0] wait_r;

    // One-cycle ack so a request still held next cycle is not answered twice
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_r <= 4'h0;
            med_ack <= 1'b0;
            med_err <= 1'b0;
        end else begin
            med_ack <= med_req && !med_ack && wait_r == lat;
            med_err <= med_req && !med_ack && wait_r == lat && med_wr && fail_wr;
            wait_r <= (med_req && !med_ack && wait_r != lat) ? wait_r + 4'h1 : 4'h0;
        end
    end
endmodule : cch_medium_model

`default_nettype wire

// *** verif/cch_cache_ctrl_tb.sv ***
// Self-checking bench of the segmented buffer cache controller
`default_nettype none

module cch_cache_ctrl_tb
    import cch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Ring length with sixteen segments; the reserve is never cache
    localparam int CAP16 = ((512 - RES_KB) * KB_BYTES / SECTOR_BYTES) / 16;
    logic clk = 0, resetn = 0, read_cache_disable = 0, write_cache_enable_flag = 0;
    logic read_ahead_disable = 0, param_check_a = 0, cfg_wr = 0, cfg_size_sent = 0;
    logic cmd_valid = 0, deferred_clr = 0, wr_valid = 0, rd_ready = 1, fail_wr = 0, stall = 0;
    logic [4:0] cfg_seg_count = 5'h01;
    logic [2:0] cmd_op = 3'h0;
    logic [15:0] cmd_lba = 16'h0000;
    logic [7:0] cmd_len = 8'h00;
    logic [3:0] lat = 4'h1;
    logic cfg_reject, prefetch_en, cmd_ready, cmd_done, cmd_good, deferred_err, xfer_paced;
    logic spindle_stop, wr_ready, rd_valid, med_req, med_wr, med_ack, med_err, seen_pc, seen_f;
    logic [4:0] seg_count;
    logic [15:0] seg_size_rpt, rd_lba, med_lba;
    logic [15:0] beats[$];
    int failures = 0, n_compared = 0, ncyc = 0, pend = 0, peak = 0, nacks = 0;

    cch_cache_ctrl i_cch_cache_ctrl (.clk, .resetn, .read_cache_disable, .write_cache_enable_flag,
        .read_ahead_disable, .param_check_a, .cfg_wr, .cfg_seg_count, .cfg_size_sent, .cfg_reject,
        .seg_count, .seg_size_rpt, .prefetch_en, .cmd_valid, .cmd_ready, .cmd_op, .cmd_lba,
        .cmd_len, .cmd_done, .cmd_good, .deferred_err, .deferred_clr, .xfer_paced, .spindle_stop,
        .wr_valid, .wr_ready, .rd_valid, .rd_ready, .rd_lba, .med_req, .med_wr, .med_lba,
        .med_ack, .med_err);
    cch_medium_model i_cch_medium_model (.clk, .resetn, .med_req, .med_wr, .lat, .fail_wr,
        .med_ack, .med_err);

    always #5 clk = ~clk;

    // Collect beats, fetches, pacing and backlog
    always @(posedge clk) begin
        ncyc++;
        if (rd_valid && rd_ready) begin
            beats.push_back(rd_lba);
        end
        seen_pc |= xfer_paced;
        seen_f |= med_req && !med_wr;
        nacks += int'(med_req && med_wr && med_ack);
        pend += int'(wr_valid && wr_ready) - int'(med_req && med_wr && med_ack);
        peak = pend > peak ? pend : peak;
    end

    // Stalled receiver takes one beat in eight
    always @(negedge clk) begin
        rd_ready <= !stall || ncyc % 8 == 0;
    end

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // Bounded wait; a hang ends the run
    task automatic wait_hi(ref logic sig);
        for (int i = 0; i < 3000 && sig !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (sig !== 1'b1) begin
            failures++;
            conclude();
        end
    endtask : wait_hi

    // One command; write blocks offered while it runs
    task automatic run(logic [2:0] op, logic [15:0] lba, logic [7:0] len);
        wait_hi(cmd_ready);
        @(negedge clk);
        cmd_op = op;
        cmd_lba = lba;
        cmd_len = len;
        cmd_valid = 1'b1;
        wr_valid = op == OP_WRITE;
        beats.delete();
        seen_pc = 1'b0;
        seen_f = 1'b0;
        @(negedge clk);
        cmd_valid = 1'b0;
        wait_hi(cmd_done);
        @(negedge clk);
        wr_valid = 1'b0;
    endtask : run

    task automatic chk_beats(logic [15:0] lba, int n);
        for (int i = 0; i < 200 && beats.size() < n; i++) begin
            @(posedge clk);
        end
        check("beats", 16'(n), 16'(beats.size()));
        for (int i = 0; i < beats.size(); i++) begin
            check("beat lba", lba + 16'(i), beats[i]);
        end
    endtask : chk_beats

    // Reject pulse may land in either cycle after the request
    task automatic cfg(logic [4:0] cnt, logic sz, logic rej);
        logic [4:0] was;
        logic seen;
        wait_hi(cmd_ready);
        @(negedge clk);
        was = seg_count;
        cfg_seg_count = cnt;
        cfg_size_sent = sz;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        seen = cfg_reject;
        @(negedge clk);
        seen |= cfg_reject;
        check("reject", 16'(rej), 16'(seen));
        check("seg count", 16'(rej ? was : cnt), 16'(seg_count));
        check("size rpt", SIZE_RPT, seg_size_rpt);
    endtask : cfg

    task automatic t_reset();
        check("seg count", 16'(SEG_DEF), 16'(seg_count));
        check("size rpt", SIZE_RPT, seg_size_rpt);
        read_cache_disable = 1'b1;
        repeat (2) @(negedge clk);
        check("prefetch", 16'h0001, 16'(prefetch_en));
        read_ahead_disable = 1'b1;
        repeat (2) @(negedge clk);
        check("prefetch", 16'h0000, 16'(prefetch_en));
        read_ahead_disable = 1'b0;
        read_cache_disable = 1'b0;
    endtask : t_reset

    task automatic t_config();
        cfg(5'h00, 1'b0, 1'b1);
        cfg(5'h11, 1'b0, 1'b1);
        cfg(5'h10, 1'b0, 1'b0);
        param_check_a = 1'b1;
        cfg(5'h04, 1'b1, 1'b1);
        param_check_a = 1'b0;
        cfg(5'h04, 1'b1, 1'b0);
    endtask : t_config

    task automatic t_read();
        run(OP_READ, 16'h0100, 8'h02);
        check("paced", 16'h0001, 16'(seen_pc));
        chk_beats(16'h0100, 2);
        run(OP_READ, 16'h0100, 8'h03);
        check("fetch", 16'h0001, 16'(seen_f));
        chk_beats(16'h0100, 3);
        stall = 1'b1;
        run(OP_READ, 16'h0100, 8'h03);
        check("paced", 16'h0000, 16'(seen_pc));
        check("fetch", 16'h0000, 16'(seen_f));
        chk_beats(16'h0100, 3);
        stall = 1'b0;
        read_cache_disable = 1'b1;
        run(OP_READ, 16'h0100, 8'h01);
        check("fetch", 16'h0001, 16'(seen_f));
        check("seg count", 16'h0004, 16'(seg_count));
        read_cache_disable = 1'b0;
    endtask : t_read

    task automatic t_write();
        write_cache_enable_flag = 1'b1;
        run(OP_WRITE, 16'h0101, 8'h01);
        check("good", 16'h0001, 16'(cmd_good));
        run(OP_READ, 16'h0101, 8'h01);
        check("fetch", 16'h0000, 16'(seen_f));
        run(OP_READ, 16'h0100, 8'h01);
        check("fetch", 16'h0001, 16'(seen_f));
        fail_wr = 1'b1;
        run(OP_WRITE, 16'h0300, 8'h01);
        check("good", 16'h0001, 16'(cmd_good));
        wait_hi(deferred_err);
        check("med lba", 16'h0300, med_lba);
        @(negedge clk);
        deferred_clr = 1'b1;
        @(negedge clk);
        deferred_clr = 1'b0;
        check("deferred", 16'h0000, 16'(deferred_err));
        write_cache_enable_flag = 1'b0;
        run(OP_WRITE, 16'h0300, 8'h01);
        check("good", 16'h0000, 16'(cmd_good));
        fail_wr = 1'b0;
    endtask : t_write

    task automatic t_flush();
        write_cache_enable_flag = 1'b1;
        lat = 4'h8;
        nacks = 0;
        run(OP_WRITE, 16'h0400, 8'h04);
        run(OP_SYNC, 16'h0000, 8'h00);
        check("commits", 16'h0004, 16'(nacks));
        nacks = 0;
        run(OP_WRITE, 16'h0500, 8'h02);
        run(OP_STOP, 16'h0000, 8'h00);
        @(negedge clk);
        check("commits", 16'h0002, 16'(nacks));
        check("stopped", 16'h0001, 16'(spindle_stop));
        run(OP_START, 16'h0000, 8'h00);
        @(negedge clk);
        check("stopped", 16'h0000, 16'(spindle_stop));
    endtask : t_flush

    task automatic t_stall();
        cfg(5'h10, 1'b0, 1'b0);
        lat = 4'hf;
        peak = 0;
        run(OP_WRITE, 16'h0600, 8'h3c);
        run(OP_SYNC, 16'h0000, 8'h00);
        check("backlog", 16'(CAP16), 16'(peak));
        check("good", 16'h0001, 16'(cmd_good));
    endtask : t_stall

    // Six reset cycles, then the scenarios
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_config();
        t_read();
        t_write();
        t_flush();
        t_stall();
        conclude();
    end
endmodule : cch_cache_ctrl_tb

`default_nettype wire
